// File: atsc_regs.svh
// Offsets, field positions, reset values and parameter-use masks of the card task file.
`ifndef ATSC_REGS_SVH
`define ATSC_REGS_SVH

// ==========================================================================
// Task-file offsets (tf_addr)
`define ATSC_OFF_FEAT     4'h1
`define ATSC_OFF_CNT      4'h2
`define ATSC_OFF_SECT     4'h3
`define ATSC_OFF_CYLL     4'h4
`define ATSC_OFF_CYLH     4'h5
`define ATSC_OFF_UHS      4'h6
`define ATSC_OFF_STAT     4'h7
`define ATSC_OFF_CTL      4'hE

// ==========================================================================
// Unit/head select fields
`define ATSC_UHS_LIN      6
`define ATSC_UHS_UNIT     4
`define ATSC_UHS_FORCE    8'hA0
`define ATSC_UHS_RST      8'hA0
`define ATSC_CNT_RST      8'h01

// ==========================================================================
// Status, error and control fields
`define ATSC_ST_BUSY      7
`define ATSC_ST_READY     6
`define ATSC_ST_FAULT     5
`define ATSC_ST_SEEK      4
`define ATSC_ST_XFER      3
`define ATSC_ST_FIXED     2
`define ATSC_ST_INDEX     1
`define ATSC_ST_ERR       0
`define ATSC_ERR_ABRT     2
`define ATSC_CTL_IRQ_DIS  1

// ==========================================================================
// Parameter-use mask bit positions
`define ATSC_USE_FEATURE  6
`define ATSC_USE_COUNT    5
`define ATSC_USE_SECTOR   4
`define ATSC_USE_TRACK    3
`define ATSC_USE_DR       2
`define ATSC_USE_HEAD     1
`define ATSC_USE_LINEAR   0
`define ATSC_USE_NONE     7'h04
`define ATSC_USE_SETGEO   7'h26
`define ATSC_USE_MEDIA    7'h3F
`define ATSC_USE_NOSC     7'h1F
`define ATSC_USE_FMT      7'h2F
`define ATSC_USE_CNT_ONLY 7'h24
`define ATSC_USE_FEAT     7'h44
`define ATSC_USE_DRHD     7'h06

`endif

// File: atsc_pkg.sv
// Types shared by both ends of the task-file link.
package atsc_pkg;

  typedef logic [6:0] atsc_use_t;

  typedef enum logic [1:0] {
    ATSC_DEV_IDLE  = 2'b00,
    ATSC_DEV_BUSY  = 2'b01,
    ATSC_DEV_ABORT = 2'b11
  } atsc_dev_state_e;

  typedef enum logic [1:0] {
    ATSC_HST_IDLE = 2'b00,
    ATSC_HST_STRB = 2'b01,
    ATSC_HST_DATA = 2'b11
  } atsc_hst_state_e;

  typedef struct packed {
    atsc_dev_state_e st;
    logic [7:0]      feat;
    logic [7:0]      cnt;
    logic [7:0]      sect;
    logic [7:0]      cyll;
    logic [7:0]      cylh;
    logic [7:0]      uhs;
    logic            xfer_flag;
    logic            fault;
    logic            fixed;
    logic            err;
    logic            abrt;
    logic            irq_pend;
    logic            irq_dis;
    logic [7:0]      rdata;
    logic            cmd_valid;
    logic [7:0]      cmd_op;
    atsc_use_t       cmd_use;
    logic [7:0]      cmd_feat;
    logic [7:0]      cmd_cnt;
    logic [27:0]     cmd_addr;
    logic            cmd_unit;
    logic            cmd_lin;
  } atsc_dev_s;

  typedef struct packed {
    atsc_hst_state_e st;
    logic            pend_cmd;
    logic [3:0]      addr;
    logic [7:0]      wdata;
    logic [7:0]      cmd;
    logic            wr;
    logic            rd;
    logic            rsp_valid;
    logic [7:0]      rsp_data;
  } atsc_hst_s;

endpackage : atsc_pkg

// File: atsc_if.sv
// Byte-wide task-file bus between the host master and the card.
`timescale 1ns/100ps
`default_nettype none
interface atsc_if;
  logic [3:0] tf_addr;
  logic       tf_wr;
  logic       tf_rd;
  logic [7:0] tf_wdata;
  logic [7:0] tf_rdata;
  logic       host_irq;

  modport dev (input tf_addr, input tf_wr, input tf_rd, input tf_wdata, output tf_rdata, output host_irq);
  modport host (output tf_addr, output tf_wr, output tf_rd, output tf_wdata, input tf_rdata, input host_irq);
endinterface : atsc_if
`default_nettype wire

// File: atsc_dev.sv
// Card end: unit/head select, status, status mirror and command register.
`timescale 1ns/100ps
`default_nettype none
`include "atsc_regs.svh"
module atsc_dev
  import atsc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  atsc_if.dev              bus,
  input  wire logic        unit_id_i,
  input  wire logic [1:0]  cfg_index_i,
  input  wire logic        level_irq_i,
  input  wire logic        unit_ready_i,
  input  wire logic        seek_done_i,
  input  wire logic        xfer_req_i,
  input  wire logic        op_done_i,
  input  wire logic        op_error_i,
  input  wire logic        op_fault_i,
  input  wire logic        op_fixed_i,
  input  wire logic [7:0]  err_code_i,
  output logic             cmd_valid_o,
  output logic [7:0]       cmd_op_o,
  output logic [6:0]       cmd_use_o,
  output logic [7:0]       cmd_feat_o,
  output logic [7:0]       cmd_cnt_o,
  output logic [27:0]      cmd_addr_o,
  output logic             cmd_unit_o,
  output logic             cmd_lin_o,
  output logic             busy_o
);

  atsc_dev_s state_reg;
  atsc_dev_s state_next;

  // ========================================================================
  // Opcode decoding
  // Which task-file fields an opcode consumes; unknown opcodes use only the unit bit.
  function automatic atsc_use_t use_of(input logic [7:0] op);
    casez (op)
      8'h91:                       use_of = `ATSC_USE_SETGEO;
      8'h90:                       use_of = `ATSC_USE_NONE;
      8'hCD, 8'h38:                use_of = `ATSC_USE_MEDIA;
      8'hC0, 8'hC4, 8'hC5, 8'h87,
      8'h20, 8'h21, 8'h40, 8'h41,
      8'h30, 8'h31, 8'h3C:         use_of = `ATSC_USE_MEDIA;
      8'h22, 8'h23, 8'h32, 8'h33,
      8'h7?:                       use_of = `ATSC_USE_NOSC;
      8'h50:                       use_of = `ATSC_USE_FMT;
      8'hE3, 8'h97, 8'hC6:         use_of = `ATSC_USE_CNT_ONLY;
      8'hEF:                       use_of = `ATSC_USE_FEAT;
      8'hF5:                       use_of = `ATSC_USE_DRHD;
      default:                     use_of = `ATSC_USE_NONE;
    endcase
  endfunction : use_of

  // Read, write and seek class: every opcode that carries a sector address, except 8'h87.
  function automatic logic is_media(input logic [7:0] op);
    atsc_use_t u;
    u = use_of(op);
    is_media = u[`ATSC_USE_SECTOR] && (op != 8'h87);
  endfunction : is_media

  // ========================================================================
  // Status composition
  logic [7:0] status;
  logic       stat_rd;
  logic       cmd_wr;
  logic       io_level;
  logic       xfer_rise;
  atsc_use_t  wr_use;

  always_comb begin
    status                 = 8'h00;
    status[`ATSC_ST_BUSY]  = (state_reg.st != ATSC_DEV_IDLE);
    status[`ATSC_ST_READY] = unit_ready_i;
    status[`ATSC_ST_FAULT] = state_reg.fault;
    status[`ATSC_ST_SEEK]  = seek_done_i;
    status[`ATSC_ST_XFER]  = state_reg.xfer_flag;
    status[`ATSC_ST_FIXED] = state_reg.fixed;
    status[`ATSC_ST_INDEX] = 1'b0;
    status[`ATSC_ST_ERR]   = state_reg.err;
  end

  assign stat_rd  = bus.tf_rd && (bus.tf_addr == `ATSC_OFF_STAT);
  assign cmd_wr   = bus.tf_wr && (bus.tf_addr == `ATSC_OFF_STAT);
  assign io_level = (cfg_index_i != 2'b00) && level_irq_i;
  assign xfer_rise = xfer_req_i && !state_reg.xfer_flag;
  assign wr_use   = use_of(bus.tf_wdata);

  // ========================================================================
  // Next-state logic
  always_comb begin
    state_next           = state_reg;
    state_next.cmd_valid = 1'b0;

    // Parameter registers only load while idle, so a running command sees stable fields.
    if (bus.tf_wr && state_reg.st == ATSC_DEV_IDLE) begin
      case (bus.tf_addr)
        `ATSC_OFF_FEAT: state_next.feat = bus.tf_wdata;
        `ATSC_OFF_CNT:  state_next.cnt  = bus.tf_wdata;
        `ATSC_OFF_SECT: state_next.sect = bus.tf_wdata;
        `ATSC_OFF_CYLL: state_next.cyll = bus.tf_wdata;
        `ATSC_OFF_CYLH: state_next.cylh = bus.tf_wdata;
        `ATSC_OFF_UHS:  state_next.uhs  = bus.tf_wdata | `ATSC_UHS_FORCE;
        default:        state_next.uhs  = state_reg.uhs;
      endcase
    end
    if (bus.tf_wr && bus.tf_addr == `ATSC_OFF_CTL) begin
      state_next.irq_dis = bus.tf_wdata[`ATSC_CTL_IRQ_DIS];
    end

    // Reading the primary status drops the request only when cfg_index_i is nonzero and level_irq_i is set; the mirror never does.
    if (stat_rd && io_level) begin
      state_next.irq_pend = 1'b0;
    end

    if (xfer_req_i) begin
      state_next.xfer_flag = 1'b1;
    end else if (op_done_i) begin
      state_next.xfer_flag = 1'b0;
    end

    case (state_reg.st)
      ATSC_DEV_IDLE: begin
        if (cmd_wr && bus.tf_wdata != 8'h90 && state_reg.uhs[`ATSC_UHS_UNIT] != unit_id_i) begin
          state_next.st = ATSC_DEV_IDLE;
        end else if (cmd_wr && is_media(bus.tf_wdata) && !(unit_ready_i && seek_done_i)) begin
          state_next.err      = 1'b1;
          state_next.abrt     = 1'b1;
          state_next.irq_pend = 1'b1;
        end else if (cmd_wr) begin
          state_next.st        = ATSC_DEV_BUSY;
          state_next.err       = 1'b0;
          state_next.abrt      = 1'b0;
          state_next.fault     = 1'b0;
          state_next.fixed     = 1'b0;
          state_next.xfer_flag = xfer_req_i;
          state_next.irq_pend  = 1'b0;
          state_next.cmd_valid = 1'b1;
          state_next.cmd_op    = bus.tf_wdata;
          state_next.cmd_use   = wr_use;
          state_next.cmd_feat  = wr_use[`ATSC_USE_FEATURE] ? state_reg.feat : 8'h00;
          state_next.cmd_cnt   = wr_use[`ATSC_USE_COUNT] ? state_reg.cnt : 8'h00;
          state_next.cmd_unit  = state_reg.uhs[`ATSC_UHS_UNIT];
          state_next.cmd_lin   = wr_use[`ATSC_USE_LINEAR] & state_reg.uhs[`ATSC_UHS_LIN];
          state_next.cmd_addr  = {wr_use[`ATSC_USE_HEAD] ? state_reg.uhs[3:0] : 4'h0,
                                  wr_use[`ATSC_USE_TRACK] ? {state_reg.cylh, state_reg.cyll} : 16'h0000,
                                  wr_use[`ATSC_USE_SECTOR] ? state_reg.sect : 8'h00};
        end
      end
      ATSC_DEV_BUSY: begin
        if (cmd_wr) begin
          state_next.st = ATSC_DEV_ABORT;
        end
        // An opcode meeting the completing edge is reported at once; no second done pulse will come.
        if (op_done_i) begin
          state_next.st    = ATSC_DEV_IDLE;
          state_next.err   = op_error_i | cmd_wr;
          state_next.abrt  = cmd_wr;
          state_next.fault = op_fault_i;
          state_next.fixed = op_fixed_i;
        end
      end
      ATSC_DEV_ABORT: begin
        // The refused opcode is reported only once the running operation ends.
        if (op_done_i) begin
          state_next.st    = ATSC_DEV_IDLE;
          state_next.err   = 1'b1;
          state_next.abrt  = 1'b1;
          state_next.fault = op_fault_i;
          state_next.fixed = op_fixed_i;
        end
      end
      default: state_next.st = ATSC_DEV_IDLE;
    endcase

    // Completion and a fresh transfer request both raise the request; set beats the read clear.
    if (op_done_i || xfer_rise) begin
      state_next.irq_pend = 1'b1;
    end

    if (bus.tf_rd) begin
      case (bus.tf_addr)
        `ATSC_OFF_FEAT: state_next.rdata = err_code_i | (8'(state_reg.abrt) << `ATSC_ERR_ABRT);
        `ATSC_OFF_CNT:  state_next.rdata = state_reg.cnt;
        `ATSC_OFF_SECT: state_next.rdata = state_reg.sect;
        `ATSC_OFF_CYLL: state_next.rdata = state_reg.cyll;
        `ATSC_OFF_CYLH: state_next.rdata = state_reg.cylh;
        `ATSC_OFF_UHS:  state_next.rdata = state_reg.uhs;
        `ATSC_OFF_STAT: state_next.rdata = status;
        `ATSC_OFF_CTL:  state_next.rdata = status;
        default:        state_next.rdata = 8'h00;
      endcase
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg      <= '0;
      state_reg.st   <= ATSC_DEV_IDLE;
      state_reg.cnt  <= `ATSC_CNT_RST;
      state_reg.uhs  <= `ATSC_UHS_RST;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  assign bus.tf_rdata  = state_reg.rdata;
  assign bus.host_irq  = state_reg.irq_pend && !state_reg.irq_dis;
  assign cmd_valid_o   = state_reg.cmd_valid;
  assign cmd_op_o      = state_reg.cmd_op;
  assign cmd_use_o     = state_reg.cmd_use;
  assign cmd_feat_o    = state_reg.cmd_feat;
  assign cmd_cnt_o     = state_reg.cmd_cnt;
  assign cmd_addr_o    = state_reg.cmd_addr;
  assign cmd_unit_o    = state_reg.cmd_unit;
  assign cmd_lin_o     = state_reg.cmd_lin;
  assign busy_o        = status[`ATSC_ST_BUSY];

endmodule : atsc_dev
`default_nettype wire

// File: atsc_host.sv
// Host end: byte-wide task-file master that holds opcodes until the card is ready.
`timescale 1ns/100ps
`default_nettype none
`include "atsc_regs.svh"
module atsc_host
  import atsc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  atsc_if.host             bus,
  input  wire logic        req_valid_i,
  input  wire logic        req_write_i,
  input  wire logic [3:0]  req_addr_i,
  input  wire logic [7:0]  req_wdata_i,
  output logic             req_ready_o,
  output logic             rsp_valid_o,
  output logic [7:0]       rsp_data_o,
  output logic             irq_o
);

  atsc_hst_s state_reg;
  atsc_hst_s state_next;

  // ========================================================================
  // Next-state logic
  always_comb begin
    state_next           = state_reg;
    state_next.wr        = 1'b0;
    state_next.rd        = 1'b0;
    state_next.rsp_valid = 1'b0;

    case (state_reg.st)
      ATSC_HST_IDLE: begin
        if (req_valid_i && req_write_i && req_addr_i == `ATSC_OFF_STAT) begin
          // Opcodes wait behind a mirror poll so the opcode lands only while the card shows ready and not busy.
          state_next.pend_cmd = 1'b1;
          state_next.cmd      = req_wdata_i;
          state_next.addr     = `ATSC_OFF_CTL;
          state_next.rd       = 1'b1;
          state_next.st       = ATSC_HST_STRB;
        end else if (req_valid_i) begin
          state_next.addr  = req_addr_i;
          state_next.wdata = req_wdata_i;
          state_next.wr    = req_write_i;
          state_next.rd    = !req_write_i;
          state_next.st    = req_write_i ? ATSC_HST_IDLE : ATSC_HST_STRB;
        end
      end
      ATSC_HST_STRB: state_next.st = ATSC_HST_DATA;
      ATSC_HST_DATA: begin
        if (!state_reg.pend_cmd) begin
          state_next.rsp_valid = 1'b1;
          state_next.rsp_data  = bus.tf_rdata;
          state_next.st        = ATSC_HST_IDLE;
        end else if (!bus.tf_rdata[`ATSC_ST_BUSY] && bus.tf_rdata[`ATSC_ST_READY]) begin
          state_next.pend_cmd = 1'b0;
          state_next.addr     = `ATSC_OFF_STAT;
          state_next.wdata    = state_reg.cmd;
          state_next.wr       = 1'b1;
          state_next.st       = ATSC_HST_IDLE;
        end else begin
          state_next.rd = 1'b1;
          state_next.st = ATSC_HST_STRB;
        end
      end
      default: state_next.st = ATSC_HST_IDLE;
    endcase
  end

  // ========================================================================
  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg    <= '0;
      state_reg.st <= ATSC_HST_IDLE;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  assign req_ready_o  = (state_reg.st == ATSC_HST_IDLE);
  assign rsp_valid_o  = state_reg.rsp_valid;
  assign rsp_data_o   = state_reg.rsp_data;
  assign irq_o        = bus.host_irq;
  assign bus.tf_addr  = state_reg.addr;
  assign bus.tf_wdata = state_reg.wdata;
  assign bus.tf_wr    = state_reg.wr;
  assign bus.tf_rd    = state_reg.rd;

endmodule : atsc_host
`default_nettype wire

// File: atsc_tf_assertions.sv
// Concurrent checks on the task-file link between the host and card ends.
`timescale 1ns/100ps
`default_nettype none
`include "atsc_regs.svh"
module atsc_tf_assertions (
  input wire logic       clk_i,
  input wire logic       nrst_i,
  input wire logic [3:0] tf_addr,
  input wire logic       tf_wr,
  input wire logic       tf_rd,
  input wire logic [7:0] tf_wdata,
  input wire logic [7:0] tf_rdata,
  input wire logic       host_irq
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // ==========================================================================
  // Helper state
  // The mask bit is tracked from the wire, so the irq check needs no design internals.
  logic dis_reg;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) dis_reg <= 1'b0;
    else if (tf_wr && tf_addr == `ATSC_OFF_CTL) dis_reg <= tf_wdata[`ATSC_CTL_IRQ_DIS];
  end

  // ==========================================================================
  // Assertions
  uhs_fixed_ones_a: assert property (tf_rd && tf_addr == `ATSC_OFF_UHS |=> tf_rdata[7] && tf_rdata[5])
    else $error("unit/head bits 7 or 5 read zero");
  index_reads_zero_a: assert property ((tf_rd && (tf_addr == `ATSC_OFF_STAT || tf_addr == `ATSC_OFF_CTL))
    |=> !tf_rdata[`ATSC_ST_INDEX])
    else $error("index bit read one");
  mirror_keeps_irq_a: assert property (tf_rd && tf_addr == `ATSC_OFF_CTL && host_irq |=> host_irq)
    else $error("mirror read dropped irq");
  irq_masked_a: assert property (dis_reg |-> !host_irq)
    else $error("irq active while disabled");
  opcode_after_ready_a: assert property (tf_wr && tf_addr == `ATSC_OFF_STAT
    |-> !tf_rdata[`ATSC_ST_BUSY] && tf_rdata[`ATSC_ST_READY])
    else $error("opcode written without ready status");
  rdata_holds_a: assert property (!$past(tf_rd) |-> $stable(tf_rdata))
    else $error("read data changed without a read");
  strobe_excl_a: assert property (!(tf_rd && tf_wr))
    else $error("read and write strobes together");
  strobe_pulse_a: assert property (tf_rd |=> !tf_rd)
    else $error("read strobe longer than one cycle");

  cover property (tf_wr && tf_addr == `ATSC_OFF_STAT);
  cover property (tf_rd && tf_addr == `ATSC_OFF_STAT && host_irq);
  cover property (tf_rd && tf_addr == `ATSC_OFF_CTL && host_irq);
endmodule : atsc_tf_assertions
`default_nettype wire

// File: ata_task_file_status_command_bench.sv
// Self-checking bench joining the host and card ends of the task file.
`timescale 1ns/100ps
`default_nettype none
`include "atsc_regs.svh"
module ata_task_file_status_command_bench;
  import atsc_pkg::*;
  logic        clk_i = 1'b0, nrst_i = 1'b0, ce_i = 1'b1;
  logic        unit_id = 1'b0, level_irq = 1'b1, unit_ready = 1'b1, seek_done = 1'b1, xfer_req = 1'b0;
  logic [1:0]  cfg_index = 2'd1;
  logic        op_done = 1'b0, op_error = 1'b0, op_fault = 1'b0, op_fixed = 1'b0;
  logic [7:0]  err_code = 8'h00, req_wdata = 8'h00, cmd_op, cmd_feat, cmd_cnt, rsp_data, q;
  logic        req_valid = 1'b0, req_write = 1'b0, req_ready, rsp_valid, irq, cmd_valid, cmd_unit, cmd_lin, busy;
  logic [3:0]  req_addr = 4'h0;
  logic [6:0]  cmd_use, u;
  logic [27:0] cmd_addr;
  logic [7:0]  p [1:6];
  logic [7:0]  ops [4] = '{8'h91, 8'h90, 8'hCD, 8'h38};
  logic        e, f, x;
  int          errors = 0, tests_run = 0, n_cmd = 0, c0, k, seed_v;

  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;

  atsc_if link ();
  atsc_dev atsc_dev_i (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .bus(link.dev), .unit_id_i(unit_id),
    .cfg_index_i(cfg_index), .level_irq_i(level_irq), .unit_ready_i(unit_ready), .seek_done_i(seek_done),
    .xfer_req_i(xfer_req), .op_done_i(op_done), .op_error_i(op_error), .op_fault_i(op_fault),
    .op_fixed_i(op_fixed), .err_code_i(err_code), .cmd_valid_o(cmd_valid), .cmd_op_o(cmd_op),
    .cmd_use_o(cmd_use), .cmd_feat_o(cmd_feat), .cmd_cnt_o(cmd_cnt), .cmd_addr_o(cmd_addr),
    .cmd_unit_o(cmd_unit), .cmd_lin_o(cmd_lin), .busy_o(busy));
  atsc_host atsc_host_i (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .bus(link.host), .req_valid_i(req_valid),
    .req_write_i(req_write), .req_addr_i(req_addr), .req_wdata_i(req_wdata), .req_ready_o(req_ready),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .irq_o(irq));
  atsc_tf_assertions atsc_tf_assertions_i (.clk_i(clk_i), .nrst_i(nrst_i), .tf_addr(link.tf_addr),
    .tf_wr(link.tf_wr), .tf_rd(link.tf_rd), .tf_wdata(link.tf_wdata), .tf_rdata(link.tf_rdata),
    .host_irq(link.host_irq));

  // ==========================================================================
  // Tasks
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : check

  // One host request; reads return the byte, writes wait until the host is idle again.
  task automatic host_op(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [7:0] r);
    int n = 0;
    while (req_ready !== 1'b1 && n < 500) begin @(negedge clk_i); n++; end
    @(posedge clk_i);
    req_valid <= 1'b1; req_write <= wr; req_addr <= a; req_wdata <= d;
    @(posedge clk_i);
    req_valid <= 1'b0;
    @(negedge clk_i);
    r = 8'h00;
    if (!wr) begin
      while (rsp_valid !== 1'b1 && n < 500) begin @(negedge clk_i); n++; end
      r = rsp_data;
    end else while (req_ready !== 1'b1 && n < 500) begin @(negedge clk_i); n++; end
    if (n >= 500) errors++;
  endtask : host_op

  task automatic end_op(input logic ev, input logic fv, input logic xv);
    @(posedge clk_i);
    op_done <= 1'b1; op_error <= ev; op_fault <= fv; op_fixed <= xv;
    @(posedge clk_i);
    op_done <= 1'b0;
    @(negedge clk_i);
  endtask : end_op

  function automatic logic [6:0] exp_use(input logic [7:0] op);
    case (op)
      8'h91:   return 7'h26;
      8'h90:   return 7'h04;
      default: return 7'h3F;
    endcase
  endfunction : exp_use

  function automatic logic [7:0] st(input logic b, r, fl, s, d, fx, er);
    return {b, r, fl, s, d, fx, 1'b0, er};
  endfunction : st

  // ==========================================================================
  // Tests
  initial begin
    seed_v = $urandom(32'h4c39);
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    host_op(1'b0, `ATSC_OFF_UHS, 8'h00, q); check("uhs reset", 8'hA0, q);
    host_op(1'b0, `ATSC_OFF_CNT, 8'h00, q); check("count reset", 8'h01, q);
    host_op(1'b0, `ATSC_OFF_STAT, 8'h00, q); check("status reset", st(0, 1, 0, 1, 0, 0, 0), q);
    host_op(1'b0, 4'h9, 8'h00, q); check("unmapped", 8'h00, q);
    $display("test reset values done");
    repeat (8) begin
      p[6] = $urandom;
      host_op(1'b1, `ATSC_OFF_UHS, p[6], q);
      host_op(1'b0, `ATSC_OFF_UHS, 8'h00, q); check("uhs readback", p[6] | 8'hA0, q);
    end
    $display("test unit/head fields done");
    foreach (ops[i]) begin
      for (int j = 1; j <= 6; j++) p[j] = $urandom;
      @(posedge clk_i); unit_id <= p[6][4];
      for (int j = 1; j <= 6; j++) host_op(1'b1, j[3:0], p[j], q);
      c0 = n_cmd;
      host_op(1'b1, `ATSC_OFF_STAT, ops[i], q);
      k = 0;
      while (n_cmd == c0 && k < 10) begin @(negedge clk_i); k++; end
      check("cmd issued", c0 + 1, n_cmd);
      u = exp_use(ops[i]);
      check("cmd op", ops[i], cmd_op);
      check("busy out", 1'b1, busy);
      check("cmd use", u, cmd_use);
      check("cmd feat", u[6] ? p[1] : 8'h00, cmd_feat);
      check("cmd cnt", u[5] ? p[2] : 8'h00, cmd_cnt);
      check("cmd addr", {u[1] ? p[6][3:0] : 4'h0, u[3] ? {p[5], p[4]} : 16'h0, u[4] ? p[3] : 8'h00}, cmd_addr);
      check("cmd unit", u[2] & p[6][4], cmd_unit);
      check("cmd lin", u[0] & p[6][6], cmd_lin);
      host_op(1'b0, `ATSC_OFF_STAT, 8'h00, q); check("busy bit", 1'b1, q[7]);
      check("err cleared", 1'b0, q[0]);
      host_op(1'b1, `ATSC_OFF_UHS, ~p[6], q);
      host_op(1'b0, `ATSC_OFF_UHS, 8'h00, q); check("uhs kept busy", p[6] | 8'hA0, q);
      e = $urandom; f = $urandom; x = $urandom;
      @(posedge clk_i); err_code <= $urandom & 8'hFB;
      end_op(e, f, x);
      check("irq done", 1'b1, irq);
      check("busy end", 1'b0, busy);
      host_op(1'b0, `ATSC_OFF_STAT, 8'h00, q); check("status done", st(0, 1, f, 1, 0, x, e), q);
      check("irq read", 1'b0, irq);
      host_op(1'b0, `ATSC_OFF_FEAT, 8'h00, q); check("error reg", err_code, q);
      $display("test opcode %0h done", ops[i]);
    end
    @(posedge clk_i); seek_done <= 1'b0;
    c0 = n_cmd;
    host_op(1'b1, `ATSC_OFF_STAT, 8'h38, q);
    repeat (6) @(negedge clk_i);
    check("media refused", c0, n_cmd);
    check("irq refused", 1'b1, irq);
    host_op(1'b0, `ATSC_OFF_STAT, 8'h00, q); check("seek err", 2'b01, {q[4], q[0]});
    host_op(1'b0, `ATSC_OFF_FEAT, 8'h00, q); check("abort bit", 1'b1, q[`ATSC_ERR_ABRT]);
    @(posedge clk_i); seek_done <= 1'b1;
    @(posedge clk_i); unit_id <= ~unit_id;
    c0 = n_cmd;
    host_op(1'b1, `ATSC_OFF_STAT, 8'h20, q);
    repeat (6) @(negedge clk_i);
    check("other unit", c0, n_cmd);
    @(posedge clk_i); unit_id <= ~unit_id;
    $display("test media refusal done");
    host_op(1'b1, `ATSC_OFF_CTL, 8'h0A, q);
    @(posedge clk_i); xfer_req <= 1'b1;
    repeat (3) @(negedge clk_i);
    check("irq masked", 1'b0, irq);
    host_op(1'b0, `ATSC_OFF_CTL, 8'h00, q); check("transfer bit", 1'b1, q[`ATSC_ST_XFER]);
    host_op(1'b1, `ATSC_OFF_CTL, 8'h08, q);
    repeat (2) @(negedge clk_i);
    check("irq unmasked", 1'b1, irq);
    host_op(1'b0, `ATSC_OFF_CTL, 8'h00, q); check("irq mirror", 1'b1, irq);
    @(posedge clk_i); cfg_index <= 2'd0;
    host_op(1'b0, `ATSC_OFF_STAT, 8'h00, q); check("irq mem mode", 1'b1, irq);
    @(posedge clk_i); cfg_index <= 2'd2; level_irq <= 1'b0;
    host_op(1'b0, `ATSC_OFF_STAT, 8'h00, q); check("irq pulse mode", 1'b1, irq);
    @(posedge clk_i); level_irq <= 1'b1;
    host_op(1'b0, `ATSC_OFF_STAT, 8'h00, q); check("irq io mode", 1'b0, irq);
    @(posedge clk_i); xfer_req <= 1'b0;
    $display("test interrupt done");
    print_verdict();
  end

  initial begin
    #400000;
    errors++;
    print_verdict();
  end
endmodule : ata_task_file_status_command_bench
`default_nettype wire
